// File: verilog/acp_pkg.sv
/*
 Constants, pin positions and carrier types for the port A cell, MII and HDLC pin engine.
 Assumes a core clock, a separate link clock from the far side, and static mode selection.
*/
package acp_pkg;
   localparam int PIN_HI = 31;
   localparam int PIN_LO = 10;
   localparam int P_ENB_COL = 31;
   localparam int P_SPACE_RTS_CRS = 30;
   localparam int P_SOC_TXER = 29;
   localparam int P_RX_CELL_ENABLE_TXEN = 28;
   localparam int P_RX_START_OF_CELL_RXDV = 27;
   localparam int P_RXRDY_RXER = 26;
   localparam int P_TXD0 = 25;
   localparam int P_NIB0 = 18;
   localparam int P_SERIAL = 18;
   localparam int P_RXD0 = 10;
   localparam int CELL_BYTES = 53;
   localparam int IDX_W = 6;
   localparam int SYNC_W = 7;
   localparam int EVT_W = 3;
   localparam logic [7:0] IDLE_HDR_LAST = 8'h01;
   localparam logic [7:0] IDLE_HEC = 8'h52;
   localparam logic [7:0] IDLE_FILL = 8'h6a;
   localparam int IDLE_HDR_IDX = 3;
   localparam int IDLE_HEC_IDX = 4;
   localparam logic [2:0] NIB_LAST = 3'h1;
   localparam logic [2:0] SER_LAST = 3'h7;
   typedef logic [PIN_HI:PIN_LO] acp_pins_t;
   typedef enum logic [2:0] {MODE_CELL_MASTER, MODE_CELL_SLAVE, MODE_MII, MODE_NIBBLE, MODE_SERIAL} acp_mode_t;
   typedef enum logic [1:0] {L_IDLE, L_CELL, L_FRAME} acp_link_state_t;
   typedef struct packed {
      logic dir;
      logic [4:0] code;
   } acp_dma_t;
   typedef struct packed {
      logic collision;
      logic broken_header;
      logic rx_error;
   } acp_mii_evt_t;
endpackage : acp_pkg

// File: verilog/acp_port.sv
/*
 Port A pin engine: cell master/slave, MII, HDLC nibble and serial transmit, MII receive status.
 Assumes the link clock comes from the far party and the mode is held static during use.
*/
`timescale 1ns/1ns
module acp_port (
   // Clocks and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_link_clk,
   // Static configuration
   input wire acp_pkg::acp_mode_t i_mode,
   input wire logic i_accept_ok,
   input wire logic i_tx_abort,
   // Cell or frame loading
   input wire logic i_tx_wr_valid,
   input wire logic [7:0] i_tx_wr_data,
   output logic o_tx_wr_ready,
   // MII receive events
   output acp_pkg::acp_mii_evt_t o_mii_event,
   // Serial DMA number
   input wire logic i_dma_active,
   input wire acp_pkg::acp_dma_t i_dma_num,
   output acp_pkg::acp_dma_t o_dma_module_number,
   // Port pins
   input wire acp_pkg::acp_pins_t i_pa,
   input wire logic i_clear_to_send_n,
   output acp_pkg::acp_pins_t o_pa,
   output acp_pkg::acp_pins_t o_pa_oe
);
   logic [7:0] cell_mem [acp_pkg::CELL_BYTES];
   logic [acp_pkg::IDX_W-1:0] wr_ptr;
   logic full;
   logic [acp_pkg::EVT_W:0] cs1, cs2, cs3, csync, cprev;
   logic c_ack;
   logic [1:0] lrst;
   logic link_rst_n;
   logic [acp_pkg::SYNC_W-1:0] ls1, ls2, ls3, lsync;
   acp_pkg::acp_mode_t mode;
   logic l_full, l_accept, l_abort, l_cts_n;
   acp_pkg::acp_link_state_t state;
   logic [acp_pkg::IDX_W-1:0] idx;
   logic [2:0] phase;
   logic from_buf;
   logic ack;
   logic [acp_pkg::EVT_W-1:0] evt_tog;
   logic col_q, brk_q, err_q;
   logic [7:0] cur_byte;
   logic [2:0] last_phase;
   logic pending;
   acp_pkg::acp_pins_t pa_out, pa_oe;

   function automatic logic [7:0] idle_byte(input logic [acp_pkg::IDX_W-1:0] i);
      if (i == acp_pkg::IDX_W'(acp_pkg::IDLE_HDR_IDX)) begin
         return acp_pkg::IDLE_HDR_LAST;
      end else if (i == acp_pkg::IDX_W'(acp_pkg::IDLE_HEC_IDX)) begin
         return acp_pkg::IDLE_HEC;
      end else if (i > acp_pkg::IDX_W'(acp_pkg::IDLE_HEC_IDX)) begin
         return acp_pkg::IDLE_FILL;
      end
      return 8'h00;
   endfunction : idle_byte

   // Core side: cell buffer load
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         wr_ptr <= '0;
         full <= 1'b0;
         o_tx_wr_ready <= 1'b0;
      end else begin
         o_tx_wr_ready <= !full && !c_ack;
         if (i_tx_wr_valid && o_tx_wr_ready && !full) begin
            cell_mem[wr_ptr] <= i_tx_wr_data;
            if (wr_ptr == acp_pkg::IDX_W'(acp_pkg::CELL_BYTES - 1)) begin
               wr_ptr <= '0;
               full <= 1'b1;
               o_tx_wr_ready <= 1'b0;
            end else begin
               wr_ptr <= wr_ptr + 1'b1;
            end
         end else if (full && c_ack) begin
            full <= 1'b0;
         end
      end
   end

   // Core side: synchronise link handshake and event toggles
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         cs1 <= '0;
         cs2 <= '0;
         cs3 <= '0;
         csync <= '0;
         cprev <= '0;
         o_mii_event <= '0;
      end else begin
         cs1 <= {ack, evt_tog};
         cs2 <= cs1;
         cs3 <= cs2;
         csync <= (~(cs2 ^ cs3) & cs3) | ((cs2 ^ cs3) & csync);
         cprev <= csync;
         o_mii_event <= csync[acp_pkg::EVT_W-1:0] ^ cprev[acp_pkg::EVT_W-1:0];
      end
   end
   assign c_ack = csync[acp_pkg::EVT_W];

   // Core side: DMA module number
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         o_dma_module_number <= '0;
      end else begin
         o_dma_module_number <= i_dma_active ? i_dma_num : '0;
      end
   end

   // Link side: reset and static inputs
   always_ff @(posedge i_link_clk) begin
      lrst <= {lrst[0], i_reset_n};
   end
   assign link_rst_n = lrst[1];

   always_ff @(posedge i_link_clk) begin
      if (!link_rst_n) begin
         ls1 <= '1;
         ls2 <= '1;
         ls3 <= '1;
         lsync <= '1;
      end else begin
         ls1 <= {i_clear_to_send_n, i_mode, full, i_accept_ok, i_tx_abort};
         ls2 <= ls1;
         ls3 <= ls2;
         lsync <= (~(ls2 ^ ls3) & ls3) | ((ls2 ^ ls3) & lsync);
      end
   end
   assign l_cts_n = lsync[6];
   assign mode = acp_pkg::acp_mode_t'(lsync[5:3]);
   assign l_full = lsync[2];
   assign l_accept = lsync[1];
   assign l_abort = lsync[0];
   assign pending = l_full && !ack;
   assign cur_byte = from_buf ? cell_mem[idx] : idle_byte(idx);
   assign last_phase = (mode == acp_pkg::MODE_SERIAL) ? acp_pkg::SER_LAST : acp_pkg::NIB_LAST;

   // Link side: transfer sequencing
   always_ff @(posedge i_link_clk) begin
      if (!link_rst_n) begin
         state <= acp_pkg::L_IDLE;
         idx <= '0;
         phase <= '0;
         from_buf <= 1'b0;
         ack <= 1'b0;
      end else begin
         if (ack && !l_full) begin
            ack <= 1'b0;
         end
         case (state)
            acp_pkg::L_IDLE: begin
               idx <= '0;
               phase <= '0;
               if (mode == acp_pkg::MODE_CELL_MASTER && i_pa[acp_pkg::P_SPACE_RTS_CRS]) begin
                  state <= acp_pkg::L_CELL;
                  from_buf <= pending;
               end else if (mode == acp_pkg::MODE_CELL_SLAVE && pending) begin
                  state <= acp_pkg::L_CELL;
                  from_buf <= 1'b1;
               end else if ((mode == acp_pkg::MODE_MII && pending) ||
                            ((mode == acp_pkg::MODE_NIBBLE || mode == acp_pkg::MODE_SERIAL) &&
                             pending && !l_cts_n)) begin
                  state <= acp_pkg::L_FRAME;
                  from_buf <= 1'b1;
               end
            end
            acp_pkg::L_CELL: begin
               if (mode == acp_pkg::MODE_CELL_MASTER || i_pa[acp_pkg::P_RX_CELL_ENABLE_TXEN]) begin
                  idx <= idx + 1'b1;
                  if (idx == acp_pkg::IDX_W'(acp_pkg::CELL_BYTES - 1)) begin
                     state <= acp_pkg::L_IDLE;
                     ack <= from_buf;
                  end
               end
            end
            acp_pkg::L_FRAME: begin
               if (phase == last_phase) begin
                  phase <= '0;
                  idx <= idx + 1'b1;
                  if (idx == acp_pkg::IDX_W'(acp_pkg::CELL_BYTES - 1)) begin
                     state <= acp_pkg::L_IDLE;
                     ack <= 1'b1;
                  end
               end else begin
                  phase <= phase + 1'b1;
               end
            end
            default: state <= acp_pkg::L_IDLE;
         endcase
      end
   end

   // Link side: pin drive per mode
   always_ff @(posedge i_link_clk) begin
      if (!link_rst_n) begin
         pa_out <= '0;
         pa_oe <= '0;
      end else begin
         pa_out <= '0;
         pa_oe <= '0;
         case (mode)
            acp_pkg::MODE_CELL_MASTER: begin
               pa_oe[acp_pkg::P_ENB_COL] <= 1'b1;
               pa_oe[acp_pkg::P_SOC_TXER] <= 1'b1;
               pa_oe[acp_pkg::P_RX_CELL_ENABLE_TXEN] <= 1'b1;
               pa_out[acp_pkg::P_RX_CELL_ENABLE_TXEN] <= i_pa[acp_pkg::P_RXRDY_RXER];
               for (int b = 0; b < 8; b++) begin
                  pa_oe[acp_pkg::P_TXD0 - b] <= 1'b1;
                  pa_out[acp_pkg::P_TXD0 - b] <= (state == acp_pkg::L_CELL) && cur_byte[b];
               end
               if (state == acp_pkg::L_CELL) begin
                  pa_out[acp_pkg::P_ENB_COL] <= 1'b1;
                  pa_out[acp_pkg::P_SOC_TXER] <= (idx == '0);
               end
            end
            acp_pkg::MODE_CELL_SLAVE: begin
               pa_oe[acp_pkg::P_SPACE_RTS_CRS] <= 1'b1;
               pa_oe[acp_pkg::P_RXRDY_RXER] <= 1'b1;
               pa_out[acp_pkg::P_SPACE_RTS_CRS] <= l_accept;
               pa_out[acp_pkg::P_RXRDY_RXER] <= (state == acp_pkg::L_IDLE && pending) ||
                                               (state == acp_pkg::L_CELL && idx == '0);
               if (state == acp_pkg::L_CELL && i_pa[acp_pkg::P_RX_CELL_ENABLE_TXEN]) begin
                  pa_oe[acp_pkg::P_RX_START_OF_CELL_RXDV] <= 1'b1;
                  pa_out[acp_pkg::P_RX_START_OF_CELL_RXDV] <= (idx == '0);
                  for (int b = 0; b < 8; b++) begin
                     pa_oe[acp_pkg::P_RXD0 + b] <= 1'b1;
                     pa_out[acp_pkg::P_RXD0 + b] <= cur_byte[b];
                  end
               end
            end
            acp_pkg::MODE_MII, acp_pkg::MODE_NIBBLE: begin
               for (int b = 0; b < 4; b++) begin
                  pa_oe[acp_pkg::P_NIB0 + b] <= 1'b1;
                  pa_out[acp_pkg::P_NIB0 + b] <= (state == acp_pkg::L_FRAME) &&
                                                 (phase[0] ? cur_byte[4 + b] : cur_byte[b]);
               end
               if (mode == acp_pkg::MODE_MII) begin
                  pa_oe[acp_pkg::P_SOC_TXER] <= 1'b1;
                  pa_oe[acp_pkg::P_RX_CELL_ENABLE_TXEN] <= 1'b1;
                  pa_out[acp_pkg::P_RX_CELL_ENABLE_TXEN] <= (state == acp_pkg::L_FRAME);
                  pa_out[acp_pkg::P_SOC_TXER] <= (state == acp_pkg::L_FRAME) && l_abort;
               end else begin
                  pa_oe[acp_pkg::P_SPACE_RTS_CRS] <= 1'b1;
                  pa_out[acp_pkg::P_SPACE_RTS_CRS] <= !(pending || state == acp_pkg::L_FRAME);
               end
            end
            acp_pkg::MODE_SERIAL: begin
               pa_oe[acp_pkg::P_SPACE_RTS_CRS] <= 1'b1;
               pa_out[acp_pkg::P_SPACE_RTS_CRS] <= !(pending || state == acp_pkg::L_FRAME);
               pa_oe[acp_pkg::P_SERIAL] <= 1'b1;
               pa_out[acp_pkg::P_SERIAL] <= (state == acp_pkg::L_FRAME) && cur_byte[phase];
            end
            default: ;
         endcase
      end
   end
   assign o_pa = pa_out;
   assign o_pa_oe = pa_oe;

   // Link side: MII receive status events
   always_ff @(posedge i_link_clk) begin
      if (!link_rst_n) begin
         col_q <= 1'b0;
         brk_q <= 1'b0;
         err_q <= 1'b0;
         evt_tog <= '0;
      end else begin
         col_q <= (mode == acp_pkg::MODE_MII) && i_pa[acp_pkg::P_ENB_COL];
         brk_q <= (mode == acp_pkg::MODE_MII) && i_pa[acp_pkg::P_SPACE_RTS_CRS] &&
                  !i_pa[acp_pkg::P_RX_START_OF_CELL_RXDV];
         err_q <= (mode == acp_pkg::MODE_MII) && i_pa[acp_pkg::P_RX_START_OF_CELL_RXDV] &&
                  i_pa[acp_pkg::P_RXRDY_RXER];
         evt_tog[2] <= evt_tog[2] ^ ((mode == acp_pkg::MODE_MII) && i_pa[acp_pkg::P_ENB_COL] && !col_q);
         evt_tog[1] <= evt_tog[1] ^ ((mode == acp_pkg::MODE_MII) && i_pa[acp_pkg::P_SPACE_RTS_CRS] &&
                                     !i_pa[acp_pkg::P_RX_START_OF_CELL_RXDV] && !brk_q);
         evt_tog[0] <= evt_tog[0] ^ ((mode == acp_pkg::MODE_MII) && i_pa[acp_pkg::P_RX_START_OF_CELL_RXDV] &&
                                     i_pa[acp_pkg::P_RXRDY_RXER] && !err_q);
      end
   end

   // Checks
   sequence master_cell_start_s;
      $rose(state == acp_pkg::L_CELL) && mode == acp_pkg::MODE_CELL_MASTER;
   endsequence
   sequence cell_body_s;
      ##52 (state == acp_pkg::L_CELL) ##1 (state == acp_pkg::L_IDLE);
   endsequence

   cell_length_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      master_cell_start_s |-> cell_body_s)
      else $error("cell not 53 cycles");
   enb_valid_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      (mode == acp_pkg::MODE_CELL_MASTER && pa_out[acp_pkg::P_ENB_COL]) |-> $past(state == acp_pkg::L_CELL))
      else $error("cell enable without cell data");
   soc_first_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      (mode == acp_pkg::MODE_CELL_MASTER && $past(state == acp_pkg::L_CELL && idx == '0))
      |-> pa_out[acp_pkg::P_SOC_TXER] && pa_out[acp_pkg::P_ENB_COL])
      else $error("start of cell missing on first byte");
   rxd_float_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      pa_oe[acp_pkg::P_RXD0] |-> $past(i_pa[acp_pkg::P_RX_CELL_ENABLE_TXEN]) && mode == acp_pkg::MODE_CELL_SLAVE)
      else $error("receive data driven without enable");
   rx_soc_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      (pa_oe[acp_pkg::P_RX_START_OF_CELL_RXDV] && pa_out[acp_pkg::P_RX_START_OF_CELL_RXDV]) |-> $past(idx == '0))
      else $error("receive start of cell off first byte");
   space_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      (mode == acp_pkg::MODE_CELL_SLAVE && pa_out[acp_pkg::P_SPACE_RTS_CRS]) |-> $past(l_accept))
      else $error("cell space without room");
   rx_ready_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      (mode == acp_pkg::MODE_CELL_SLAVE && pa_out[acp_pkg::P_RXRDY_RXER]) |-> $past(l_full))
      else $error("cell ready without a cell");
   txen_frame_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      ($past(mode == acp_pkg::MODE_MII) && mode == acp_pkg::MODE_MII)
      |-> pa_out[acp_pkg::P_RX_CELL_ENABLE_TXEN] == $past(state == acp_pkg::L_FRAME))
      else $error("transmit enable not matching frame");
   rts_low_a: assert property (@(posedge i_link_clk) disable iff (!link_rst_n)
      (state == acp_pkg::L_FRAME && mode == acp_pkg::MODE_SERIAL) |=> !pa_out[acp_pkg::P_SPACE_RTS_CRS])
      else $error("request to send not low during frame");
   dma_num_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      i_dma_active |=> o_dma_module_number == $past(i_dma_num))
      else $error("module number not presented");
endmodule : acp_port

// File: verification/acp_far_model.sv
/*
 Far-side model of the port A pins: cell PHY or cell master, Ethernet PHY and HDLC peer.
 Assumes the bench link clock and a bench that sets the knobs at clock edges.
*/
`timescale 1ns/1ns
module acp_far_model (
   // Link clock and mode
   input wire logic i_link_clk,
   input wire acp_pkg::acp_mode_t i_mode,
   // Knobs from the bench
   input wire logic i_space,
   input wire logic i_pull,
   input wire logic i_grant,
   input wire logic [3:0] i_mii,
   // Device pins
   input wire acp_pkg::acp_pins_t i_dev,
   output acp_pkg::acp_pins_t o_far,
   output logic o_cts_n
);
   logic tick;
   initial begin
      o_far = '0;
      o_cts_n = 1'b1;
      tick = 1'b0;
   end
   always @(posedge i_link_clk) begin
      tick <= ~tick;
      o_far[31:18] <= '0;
      o_cts_n <= ~(i_grant & ~i_dev[30]);
      // Released receive data shows the inverse of its last value
      o_far[17:10] <= ~o_far[17:10];
      case (i_mode)
         acp_pkg::MODE_CELL_MASTER: begin
            o_far[30] <= i_space;
            o_far[26] <= i_space;
            if (i_dev[28]) begin
               o_far[17:10] <= 8'h5a;
            end
         end
         acp_pkg::MODE_CELL_SLAVE: begin
            o_far[31] <= 1'b0;
            o_far[28] <= i_pull & tick;
         end
         acp_pkg::MODE_MII: begin
            {o_far[31], o_far[30], o_far[27], o_far[26]} <= i_mii;
         end
         default: begin
         end
      endcase
   end
endmodule : acp_far_model

// File: verification/test_atm_cell_mii_hdlc_port.sv
/*
 Self-checking bench for the port A pin engine with the far-side model.
 Assumes the design package and the far-side model are compiled first.
*/
`timescale 1ns/1ns
module test_atm_cell_mii_hdlc_port;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   acp_pkg::acp_mode_t mode = acp_pkg::MODE_CELL_MASTER;
   logic accept_ok = 1'b0;
   logic abort = 1'b0;
   logic wr_valid = 1'b0;
   logic [7:0] wr_data = 8'h00;
   logic wr_ready;
   acp_pkg::acp_mii_evt_t evt;
   logic dma_act = 1'b0;
   acp_pkg::acp_dma_t dma_num = '0;
   acp_pkg::acp_dma_t dma_out;
   acp_pkg::acp_pins_t pin_in;
   acp_pkg::acp_pins_t pa;
   acp_pkg::acp_pins_t pa_oe;
   logic cts_n;
   logic space = 1'b0;
   logic pull = 1'b0;
   logic grant = 1'b0;
   logic [3:0] mii = 4'h0;
   int err_total = 0;
   int comparisons = 0;

   always #25 clk = ~clk;
   initial begin
      #7;
      forever #32 lclk = ~lclk;
   end

   acp_port i_dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_link_clk(lclk), .i_mode(mode),
      .i_accept_ok(accept_ok), .i_tx_abort(abort), .i_tx_wr_valid(wr_valid), .i_tx_wr_data(wr_data),
      .o_tx_wr_ready(wr_ready), .o_mii_event(evt), .i_dma_active(dma_act), .i_dma_num(dma_num),
      .o_dma_module_number(dma_out), .i_pa(pin_in), .i_clear_to_send_n(cts_n), .o_pa(pa), .o_pa_oe(pa_oe));
   acp_far_model i_far (.i_link_clk(lclk), .i_mode(mode), .i_space(space), .i_pull(pull), .i_grant(grant),
      .i_mii(mii), .i_dev(pa), .o_far(pin_in), .o_cts_n(cts_n));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic restart(input acp_pkg::acp_mode_t m);
      @(posedge clk);
      rst_n <= 1'b0;
      mode <= m;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
   endtask : restart

   task automatic load_cell(input logic [7:0] base);
      int g;
      for (int i = 0; i < acp_pkg::CELL_BYTES; i++) begin
         wr_valid <= 1'b1;
         wr_data <= base + 8'(i);
         g = 0;
         do begin
            @(posedge clk);
            g++;
         end while (wr_ready !== 1'b1 && g < 5000);
         check(wr_ready, 1, "load ready");
      end
      wr_valid <= 1'b0;
   endtask : load_cell

   task automatic wait_link(input int pin, input logic lvl);
      int g = 0;
      while (pa[pin] !== lvl && g < 3000) begin
         @(posedge lclk);
         g++;
      end
      check(pa[pin], lvl, "link wait");
   endtask : wait_link

   function automatic logic [7:0] tx_byte(input acp_pkg::acp_pins_t p);
      for (int i = 0; i < 8; i++) begin
         tx_byte[i] = p[acp_pkg::P_TXD0 - i];
      end
   endfunction : tx_byte

   function automatic logic [7:0] idle_byte(input int k);
      if (k < acp_pkg::IDLE_HDR_IDX) return 8'h00;
      if (k == acp_pkg::IDLE_HDR_IDX) return acp_pkg::IDLE_HDR_LAST;
      if (k == acp_pkg::IDLE_HEC_IDX) return acp_pkg::IDLE_HEC;
      return acp_pkg::IDLE_FILL;
   endfunction : idle_byte

   // Loaded cell, then an idle cell
   task automatic cell_master_tx();
      restart(acp_pkg::MODE_CELL_MASTER);
      load_cell(8'h40);
      // Let the full flag reach the link side before the slave offers space
      repeat (10) @(posedge clk);
      space <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         wait_link(31, 1'b1);
         for (int k = 0; k < acp_pkg::CELL_BYTES; k++) begin
            check(pa[31], 1, "tx enable");
            check(pa[29], k == 0, "tx soc");
            check(tx_byte(pa), c == 0 ? 8'h40 + 8'(k) : idle_byte(k), "tx byte");
            @(posedge lclk);
         end
      end
      check(pa[28], 1, "rx enable");
      check({pa_oe[30], pa_oe[26], pa_oe[17:10]}, 0, "input driven");
      space <= 1'b0;
      repeat (4) @(posedge lclk);
      check(pa[28], 0, "rx enable off");
   endtask : cell_master_tx

   // Enable-paced cell read by the far master
   task automatic cell_slave_rx();
      logic prev;
      int n;
      restart(acp_pkg::MODE_CELL_SLAVE);
      accept_ok <= 1'b1;
      repeat (12) @(posedge clk);
      check(pa[30], 1, "space");
      accept_ok <= 1'b0;
      repeat (12) @(posedge clk);
      check(pa[30], 0, "space drop");
      check(pa[26], 0, "ready empty");
      load_cell(8'h80);
      wait_link(26, 1'b1);
      check({pa_oe[27], pa_oe[17:10]}, 0, "rx float");
      pull <= 1'b1;
      prev = 1'b0;
      n = 0;
      for (int t = 0; t < 300 && n < acp_pkg::CELL_BYTES; t++) begin
         @(posedge lclk);
         check({pa_oe[27], pa_oe[17:10]}, {9{prev}}, "rx enable");
         if (prev) begin
            check(pa[17:10], 8'h80 + 8'(n), "rx byte");
            check(pa[27], n == 0, "rx soc");
            n++;
         end
         prev = pin_in[28];
      end
      check(n, acp_pkg::CELL_BYTES, "rx count");
      pull <= 1'b0;
   endtask : cell_slave_rx

   // Nibble frame with transmit error held
   task automatic mii_frame();
      logic [7:0] b;
      restart(acp_pkg::MODE_MII);
      abort <= 1'b1;
      load_cell(8'h1c);
      wait_link(28, 1'b1);
      for (int k = 0; k < 2 * acp_pkg::CELL_BYTES; k++) begin
         b = 8'h1c + 8'(k / 2);
         check(pa[28], 1, "tx_en");
         check(pa[29], 1, "tx_er");
         check(pa[21:18], k[0] ? b[7:4] : b[3:0], "nibble");
         @(posedge lclk);
      end
      check(pa[29:28], 0, "frame end");
      check({pa_oe[31:30], pa_oe[27:26]}, 0, "input driven");
      @(posedge clk);
      abort <= 1'b0;
   endtask : mii_frame

   // Collision, bare carrier, receive error, clean data
   task automatic mii_events();
      logic [3:0] stim [4] = '{4'b1000, 4'b0100, 4'b0011, 4'b0110};
      logic [2:0] want [4] = '{3'b100, 3'b010, 3'b001, 3'b000};
      logic [2:0] seen;
      for (int s = 0; s < 4; s++) begin
         @(posedge clk);
         mii <= stim[s];
         seen = 3'b000;
         repeat (40) begin
            @(posedge clk);
            seen = seen | evt;
         end
         mii <= 4'h0;
         repeat (20) @(posedge clk);
         check(seen, want[s], "mii event");
      end
   endtask : mii_events

   task automatic dma_number();
      for (int d = 0; d < 2; d++) begin
         @(posedge clk);
         dma_act <= 1'b1;
         dma_num <= {d[0], 5'h0b + 5'(d)};
         @(posedge clk);
         @(posedge clk);
         check(dma_out, {d[0], 5'h0b + 5'(d)}, "dma number");
      end
      dma_act <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      check(dma_out, 0, "dma idle");
   endtask : dma_number

   task automatic hdlc_rts(input acp_pkg::acp_mode_t m);
      logic [7:0] b;
      restart(m);
      check(pa[30], 1, "rts idle");
      load_cell(8'ha5);
      repeat (20) @(posedge clk);
      check({pa_oe[30], pa[30]}, 2'b10, "rts low");
      grant <= 1'b1;
      // First frame cycle carries bit 0 of byte 0, which is high
      wait_link(18, 1'b1);
      if (m == acp_pkg::MODE_SERIAL) begin
         for (int k = 0; k < 8 * acp_pkg::CELL_BYTES; k++) begin
            b = 8'ha5 + 8'(k / 8);
            check(pa[18], b[k % 8], "serial bit");
            @(posedge lclk);
         end
      end else begin
         for (int k = 0; k < 2 * acp_pkg::CELL_BYTES; k++) begin
            b = 8'ha5 + 8'(k / 2);
            check(pa[21:18], k[0] ? b[7:4] : b[3:0], "hdlc nibble");
            @(posedge lclk);
         end
      end
      wait_link(30, 1'b1);
      check(pa[30], 1, "rts release");
      grant <= 1'b0;
   endtask : hdlc_rts

   initial begin
      cell_master_tx();
      cell_slave_rx();
      mii_frame();
      mii_events();
      dma_number();
      hdlc_rts(acp_pkg::MODE_NIBBLE);
      hdlc_rts(acp_pkg::MODE_SERIAL);
      tally_and_finish();
   end

   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      tally_and_finish();
   end
endmodule : test_atm_cell_mii_hdlc_port
